// *** logic/input_parity_and_alarm_monitor.sv ***
// Input bus parity checker and sticky alarm monitor with Wishbone registers
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns

module input_parity_and_alarm_monitor
  import parity_alarm_pkg::*;
(
  input  wire logic                               clk_i,
  input  wire logic                               rst_i,
  input  wire logic                               ce_i,
  // Wishbone slave
  input  wire logic                               cyc_i,
  input  wire logic                               stb_i,
  input  wire logic                               we_i,
  input  wire logic [7:0]                         adr_i,
  input  wire logic [3:0]                         sel_i,
  input  wire logic [31:0]                        dat_i,
  output logic      [31:0]                        dat_o,
  output logic                                    ack_o,
  // Link from the data source
  input  wire logic                               word_clk_i,
  input  wire logic [parity_alarm_pkg::DATA_W-1:0] data_i,
  input  wire logic                               check_bit_input_i,
  input  wire logic                               frame_i,
  // Device-side alarm sources
  input  wire logic                               conv_clk_toggle_i,
  input  wire logic                               pll_locked_i,
  input  wire logic                               tx_enable_i,
  input  wire logic                               pattern_mismatch_i,
  input  wire logic [parity_alarm_pkg::PTR_W-1:0]  wr_ptr_i,
  input  wire logic [parity_alarm_pkg::PTR_W-1:0]  rd_ptr_i,
  // Results
  output logic                                    alarm_o,
  output logic                                    analog_on_o
);
  import parity_alarm_pkg::*;

  logic [TEST_SETUP_W-1:0]   test_setup_register;
  logic [AUTO_SHUTOFF_W-1:0] auto_shutoff_register;
  logic [ALARM_W-1:0]        alarm_status_register;
  logic [ALARM_W-1:0]        alarm_mask_register;
  logic [ALARM_W-1:0]        events;
  logic [ALARM_W-1:0]        keep_mask;

  logic [DATA_W+3:0]         pin_meta;
  logic [DATA_W+3:0]         pin_sync;
  logic [DATA_W-1:0]         word;
  logic                      check_bit;
  logic                      frame;
  logic                      pll_locked;
  logic                      tx_enable;

  logic                      wclk_rise;
  logic                      wclk_fall;
  logic                      wclk_gone;
  logic                      cclk_gone;

  logic                      word_bad;
  logic                      rise_err;
  logic                      fall_err;
  logic                      frame_prev;
  logic                      boundary;
  logic                      block_acc;
  logic                      block_done;
  logic                      block_wait;
  logic                      block_live;
  logic                      block_err;

  logic [PTR_W-1:0]          rd_rot1_l;
  logic [PTR_W-1:0]          rd_rot1_r;
  logic [PTR_W-1:0]          rd_rot2_l;
  logic [PTR_W-1:0]          rd_rot2_r;
  logic                      ptr_equal;
  logic                      ptr_one;
  logic                      ptr_two;

  logic                      bus_req;
  logic                      bus_wr;
  logic [31:0]               next_dat;
  logic [31:0]               wmask;
  logic                      shutoff;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else if (ce_i)
    begin
      pin_meta <= {tx_enable_i, pll_locked_i, frame_i,
                   check_bit_input_i, data_i};
      pin_sync <= pin_meta;
    end
  end

  assign word       = pin_sync[DATA_W-1:0];
  assign check_bit  = pin_sync[DATA_W];
  assign frame      = pin_sync[DATA_W+1];
  assign pll_locked = pin_sync[DATA_W+2];
  assign tx_enable  = pin_sync[DATA_W+3];

  // Same two-stage delay as the data, so edges and words stay aligned
  clock_watch u_word_clk (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .pin_i  (word_clk_i),
    .rise_o (wclk_rise),
    .fall_o (wclk_fall),
    .gone_o (wclk_gone)
  );

  clock_watch u_conv_clk (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .pin_i  (conv_clk_toggle_i),
    .rise_o (),
    .fall_o (),
    .gone_o (cclk_gone)
  );

  // ************************************************************
  // Word-by-word parity
  // ************************************************************
  // Seventeen-bit XOR: high means an odd count of ones
  assign word_bad = ((^word) ^ check_bit)
                    != test_setup_register[ODD_PARITY_BIT];
  assign rise_err = test_setup_register[WORD_PARITY_ENA_BIT]
                    & wclk_rise & word_bad;
  assign fall_err = test_setup_register[WORD_PARITY_ENA_BIT]
                    & wclk_fall & word_bad;

  // ************************************************************
  // Block parity
  // ************************************************************
  assign boundary = wclk_rise & frame & ~frame_prev;
  assign block_err = block_wait & wclk_fall
                     & (frame != block_done);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      frame_prev <= 1'b0;
    else if (ce_i && wclk_rise)
      frame_prev <= frame;
  end

  // The partial block seen at enable is never judged
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !test_setup_register[BLOCK_PARITY_ENA_BIT])
    begin
      block_acc  <= 1'b0;
      block_done <= 1'b0;
      block_wait <= 1'b0;
      block_live <= 1'b0;
    end
    else if (ce_i)
    begin
      if (boundary)
      begin
        block_done <= block_acc;
        block_acc  <= ^word;
        block_wait <= block_live;
        block_live <= 1'b1;
      end
      else if (wclk_rise || wclk_fall)
      begin
        block_acc <= block_acc ^ (^word);
        if (wclk_fall)
          block_wait <= 1'b0;
      end
    end
  end

  // ************************************************************
  // FIFO pointer health
  // ************************************************************
  assign rd_rot1_l = {rd_ptr_i[PTR_W-2:0], rd_ptr_i[PTR_W-1]};
  assign rd_rot1_r = {rd_ptr_i[0], rd_ptr_i[PTR_W-1:1]};
  assign rd_rot2_l = {rd_ptr_i[PTR_W-3:0], rd_ptr_i[PTR_W-1:PTR_W-2]};
  assign rd_rot2_r = {rd_ptr_i[1:0], rd_ptr_i[PTR_W-1:2]};
  assign ptr_equal = (wr_ptr_i == rd_ptr_i);
  assign ptr_one   = (wr_ptr_i == rd_rot1_l)
                     | (wr_ptr_i == rd_rot1_r);
  assign ptr_two   = (wr_ptr_i == rd_rot2_l)
                     | (wr_ptr_i == rd_rot2_r);

  // ************************************************************
  // Alarm events
  // ************************************************************
  always_comb
  begin
    events = '0;
    events[ZERO_CHECK_BIT]    = (wr_ptr_i == '0);
    events[COLLISION_BIT]     = ptr_equal;
    events[ONE_APART_BIT]     = ptr_one;
    events[TWO_APART_BIT]     = ptr_two;
    events[FIFO_SUMMARY_BIT]  = ptr_equal | ptr_one | ptr_two;
    events[CONV_CLK_GONE_BIT] = cclk_gone;
    events[WORD_CLK_GONE_BIT] = wclk_gone;
    events[CLOCK_LOST_BIT]    = cclk_gone | wclk_gone;
    events[PATTERN_BIT]       = pattern_mismatch_i;
    events[PLL_BIT]           = ~pll_locked;
    events[RISE_PARITY_BIT]   = rise_err;
    events[FALL_PARITY_BIT]   = fall_err;
    events[BLOCK_PARITY_BIT]  = block_err;
  end

  // ************************************************************
  // Wishbone slave
  // ************************************************************
  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign bus_wr  = cyc_i & stb_i & we_i & ack_o;  // Lands as ack is sampled

  // Byte lanes not selected keep their old content
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}},
                  {8{sel_i[1]}}, {8{sel_i[0]}}};

  always_comb
  begin
    next_dat = 32'h0000_0000;
    case (adr_i)
      TEST_SETUP_OFS:
        next_dat[TEST_SETUP_W-1:0] = test_setup_register;
      AUTO_SHUTOFF_OFS:
        next_dat[AUTO_SHUTOFF_W-1:0] = auto_shutoff_register;
      ALARM_STATUS_OFS:
        next_dat[ALARM_W-1:0] = alarm_status_register;
      ALARM_MASK_OFS:
        next_dat[ALARM_W-1:0] = alarm_mask_register;
      default:
        next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      ack_o <= bus_req;
      if (bus_req && !we_i)
        dat_o <= next_dat;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      test_setup_register   <= TEST_SETUP_RST;
      auto_shutoff_register <= AUTO_SHUTOFF_RST;
      alarm_mask_register   <= ALARM_MASK_RST;
    end
    else if (ce_i && bus_wr)
    begin
      if (adr_i == TEST_SETUP_OFS)
        test_setup_register <= (test_setup_register
                                & ~wmask[TEST_SETUP_W-1:0])
                               | (dat_i[TEST_SETUP_W-1:0]
                                  & wmask[TEST_SETUP_W-1:0]);
      if (adr_i == AUTO_SHUTOFF_OFS)
        auto_shutoff_register <= (auto_shutoff_register
                                  & ~wmask[AUTO_SHUTOFF_W-1:0])
                                 | (dat_i[AUTO_SHUTOFF_W-1:0]
                                    & wmask[AUTO_SHUTOFF_W-1:0]);
      if (adr_i == ALARM_MASK_OFS)
        alarm_mask_register <= (alarm_mask_register
                                & ~wmask[ALARM_W-1:0])
                               | (dat_i[ALARM_W-1:0]
                                  & wmask[ALARM_W-1:0]);
    end
  end

  // ************************************************************
  // Sticky alarm status
  // ************************************************************
  // Zero in a selected lane clears; a new event the same cycle still wins
  assign keep_mask = (bus_wr && adr_i == ALARM_STATUS_OFS)
                     ? (dat_i[ALARM_W-1:0] | ~wmask[ALARM_W-1:0])
                     : {ALARM_W{1'b1}};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      alarm_status_register <= ALARM_STATUS_RST;
    else if (ce_i)
      alarm_status_register <= (alarm_status_register & keep_mask)
                               | events;
  end

  // ************************************************************
  // Alarm pin and analog output gate
  // ************************************************************
  // Shutoff follows the sticky flags, so analog_on_o stays off until cleared
  assign shutoff =
    (auto_shutoff_register[OFF_ON_CONV_CLK_BIT]
     & alarm_status_register[CONV_CLK_GONE_BIT])
    | (auto_shutoff_register[OFF_ON_WORD_CLK_BIT]
       & alarm_status_register[WORD_CLK_GONE_BIT])
    | (auto_shutoff_register[OFF_ON_COLLIDE_BIT]
       & alarm_status_register[COLLISION_BIT]);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      alarm_o     <= 1'b0;
      analog_on_o <= 1'b0;
    end
    else if (ce_i)
    begin
      alarm_o     <= |(alarm_status_register
                       & alarm_mask_register);
      analog_on_o <= tx_enable & ~shutoff
                     & test_setup_register[SW_TX_ENABLE_BIT];
    end
  end

endmodule // input_parity_and_alarm_monitor

// *** inc/parity_alarm_pkg.sv ***
// Shared constants for the input parity and alarm monitor
package parity_alarm_pkg;

  // ************************************************************
  // Register map (byte addresses, 32-bit words)
  // ************************************************************
  localparam logic [7:0] TEST_SETUP_OFS     = 8'h00;
  localparam logic [7:0] AUTO_SHUTOFF_OFS   = 8'h04;
  localparam logic [7:0] ALARM_STATUS_OFS   = 8'h08;
  localparam logic [7:0] ALARM_MASK_OFS     = 8'h0C;

  // ************************************************************
  // Test setup register fields
  // ************************************************************
  localparam int WORD_PARITY_ENA_BIT  = 0;
  localparam int BLOCK_PARITY_ENA_BIT = 1;
  localparam int ODD_PARITY_BIT       = 2;
  localparam int SW_TX_ENABLE_BIT     = 3;
  localparam int TEST_SETUP_W         = 4;
  localparam logic [3:0] TEST_SETUP_RST = 4'h0;

  // ************************************************************
  // Auto shutoff register fields
  // ************************************************************
  localparam int OFF_ON_CONV_CLK_BIT  = 0;
  localparam int OFF_ON_WORD_CLK_BIT  = 1;
  localparam int OFF_ON_COLLIDE_BIT   = 2;
  localparam int AUTO_SHUTOFF_W       = 3;
  localparam logic [2:0] AUTO_SHUTOFF_RST = 3'h0;

  // ************************************************************
  // Alarm status and mask fields
  // ************************************************************
  localparam int ZERO_CHECK_BIT       = 0;
  localparam int FIFO_SUMMARY_BIT     = 1;
  localparam int TWO_APART_BIT        = 2;
  localparam int ONE_APART_BIT        = 3;
  localparam int COLLISION_BIT        = 4;
  localparam int CLOCK_LOST_BIT       = 5;
  localparam int CONV_CLK_GONE_BIT    = 6;
  localparam int WORD_CLK_GONE_BIT    = 7;
  localparam int PATTERN_BIT          = 8;
  localparam int PLL_BIT              = 9;
  localparam int RISE_PARITY_BIT      = 10;
  localparam int FALL_PARITY_BIT      = 11;
  localparam int BLOCK_PARITY_BIT     = 12;
  localparam int ALARM_W              = 13;
  localparam logic [12:0] ALARM_STATUS_RST = 13'h0000;
  localparam logic [12:0] ALARM_MASK_RST   = 13'h0000;

  // ************************************************************
  // Bus and link widths
  // ************************************************************
  localparam int DATA_W = 16;
  localparam int PTR_W  = 8;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLK_GONE_NS   = 2000;
  localparam logic [7:0] CLK_GONE_CYC =
    8'((CLK_GONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// *** logic/clock_watch.sv ***
// Samples a slow clock-like pin, finds its edges, and flags it stopped
`timescale 1ns/1ns
module clock_watch
  import parity_alarm_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o,
  output logic      gone_o
);

  logic       meta;
  logic       level;
  logic       prev;
  logic [7:0] idle_cnt;

  // ************************************************************
  // Two-stage synchroniser and edge history
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta  <= 1'b0;
      level <= 1'b0;
      prev  <= 1'b0;
    end
    else if (ce_i)
    begin
      meta  <= pin_i;
      level <= meta;
      prev  <= level;
    end
  end

  assign rise_o = level & ~prev;
  assign fall_o = ~level & prev;

  // ************************************************************
  // Stall watchdog
  // ************************************************************
  // Saturates so a clock that never starts still reads as gone
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      idle_cnt <= 8'h00;
    else if (ce_i)
    begin
      if (rise_o | fall_o)
        idle_cnt <= 8'h00;
      else if (idle_cnt != CLK_GONE_CYC)
        idle_cnt <= idle_cnt + 8'h01;
    end
  end

  assign gone_o = (idle_cnt == CLK_GONE_CYC);

endmodule // clock_watch

// *** verif/link_source_model.sv ***
// Behavioural data source for the monitor's input link
`timescale 1ns/1ns
module link_source_model
(
  output logic        word_clk_o,
  output logic [15:0] data_o,
  output logic        check_bit_o,
  output logic        frame_o
);
  initial
  begin
    word_clk_o  = 1'b0;
    data_o      = 16'h0000;
    check_bit_o = 1'b0;
    frame_o     = 1'b0;
  end

  // One word per half period of 400 ns; clock stands still between calls
  task automatic half(input logic [15:0] d, input logic p, input logic f);
    // Non-blocking: a change on a clock edge is seen after that edge
    data_o      <= d;
    check_bit_o <= p;
    frame_o     <= f;
    #200 word_clk_o <= ~word_clk_o;
    #200;
  endtask

  // Released lines flip, so a stale word's parity is inverted
  task automatic rest();
    data_o      <= ~data_o;
    check_bit_o <= ~check_bit_o;
  endtask
endmodule // link_source_model

// *** verif/input_parity_and_alarm_monitor_checker.sv ***
// Concurrent checks on the monitor's bus and result ports
`timescale 1ns/1ns
module input_parity_and_alarm_monitor_checker
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_o,
  input  wire logic        ack_o,
  input  wire logic        tx_enable_i,
  input  wire logic        alarm_o,
  input  wire logic        analog_on_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ****************************************
  // Bus handshake, read data and result ports
  // ****************************************
  sequence s_take;
    cyc_i && stb_i && !ack_o && ce_i;
  endsequence

  sequence s_answer;
    ack_o ##1 !ack_o;
  endsequence

  a_ack_answers: assert property (s_take |=> s_answer)
    else $error("ack not a single pulse one cycle after request");
  a_ack_has_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_idle_no_ack: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack while bus idle");
  a_read_holds: assert property ($changed(dat_o) |-> $rose(ack_o) && !$past(we_i))
    else $error("read data moved outside a read");
  a_unmapped_zero: assert property ($rose(ack_o) && $past(!we_i &&
    (adr_i > 8'h0C || adr_i[1:0] != 2'b00)) |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_reserved_zero: assert property ($rose(ack_o) && $past(!we_i)
    |-> dat_o[31:13] == 19'h0)
    else $error("reserved read bits not zero");
  a_reset_quiet: assert property ($fell(rst_i)
    |-> !alarm_o && !analog_on_o && !ack_o)
    else $error("outputs active right after reset");
  a_tx_gates_out: assert property (!tx_enable_i [*4] |-> !analog_on_o)
    else $error("analog on with transmit pin low");
endmodule // input_parity_and_alarm_monitor_checker

bind input_parity_and_alarm_monitor input_parity_and_alarm_monitor_checker
  u_input_parity_and_alarm_monitor_checker (.clk_i, .rst_i, .ce_i, .cyc_i,
  .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .tx_enable_i, .alarm_o,
  .analog_on_o);

// *** verif/input_parity_and_alarm_monitor_test.sv ***
// Self-checking bench for the input parity and alarm monitor
`timescale 1ns/1ns
module input_parity_and_alarm_monitor_test;
  import parity_alarm_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o, alarm_o, analog_on_o;
  logic        word_clk_i, check_bit_input_i, frame_i;
  logic [15:0] data_i;
  logic        conv_clk_toggle_i = 1'b0;
  logic        pll_locked_i = 1'b1;
  logic        tx_enable_i = 1'b1;
  logic        pattern_mismatch_i = 1'b0;
  logic [7:0]  wr_ptr_i = 8'h01;
  logic [7:0]  rd_ptr_i = 8'h10;
  logic        conv_run = 1'b1;
  logic [31:0] q;
  logic [15:0] w = 16'hB38E;
  logic [63:0] blk_a = 64'h0001_0003_8000_00F0;
  logic [63:0] blk_b = 64'h1234_5678_9ABC_DEF1;
  int          err_total = 0;
  int          n_checks = 0;
  logic [7:0]  ofs [4] = '{TEST_SETUP_OFS, AUTO_SHUTOFF_OFS,
                           ALARM_MASK_OFS, 8'h10};
  logic [7:0]  wr_tab [6] = '{8'h10, 8'h20, 8'h40, 8'h80, 8'h08, 8'h04};
  logic [4:0]  fifo_exp [6] = '{5'h12, 5'h0A, 5'h06, 5'h00, 5'h0A, 5'h06};

  always #50 clk_i = ~clk_i;

  always @(posedge clk_i)
    if (conv_run)
      conv_clk_toggle_i <= ~conv_clk_toggle_i;

  input_parity_and_alarm_monitor u_input_parity_and_alarm_monitor (
    .clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .word_clk_i, .data_i, .check_bit_input_i, .frame_i,
    .conv_clk_toggle_i, .pll_locked_i, .tx_enable_i, .pattern_mismatch_i,
    .wr_ptr_i, .rd_ptr_i, .alarm_o, .analog_on_o);

  link_source_model u_link_source_model (.word_clk_o(word_clk_i),
    .data_o(data_i), .check_bit_o(check_bit_input_i), .frame_o(frame_i));

  // ****************************************
  // Bus and link tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Classic cycle; waits for ack as long as it takes, watchdog ends a hang
  task automatic wb(input logic wr, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= wr;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    while (ack_o !== 1'b1)
    begin
      @(posedge clk_i);
      n++;
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    // Ack is set at the first edge, so it is sampled high at the second
    chk(n, 32'h2);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(q & m, e);
  endtask

  task automatic clr();
    wb(1'b1, ALARM_STATUS_OFS, 32'h0, 4'hF);
  endtask

  task automatic hw(input logic [15:0] d, input logic p, input logic f);
    u_link_source_model.half(d, p, f);
  endtask

  // Frame never resyncs pointers here, so short blocks are legal
  task automatic blk(input logic [63:0] v, input logic fp);
    hw(v[15:0], 1'b0, 1'b1);
    hw(v[31:16], 1'b0, fp);
    hw(v[47:32], 1'b0, 1'b0);
    hw(v[63:48], 1'b0, 1'b0);
  endtask

  task automatic pulse();
    pattern_mismatch_i <= 1'b1;
    tick(1);
    pattern_mismatch_i <= 1'b0;
    tick(6);
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    tick(16);
    rst_i <= 1'b0;
    tick(30);
    foreach (ofs[i])
      rd(ofs[i], 32'hFFFFFFFF, 32'h0);
    rd(ALARM_STATUS_OFS, 32'hA0, 32'hA0);
    wb(1'b1, 8'h10, 32'hFFFFFFFF, 4'hF);
    wb(1'b1, TEST_SETUP_OFS, 32'hFFFFFFFF, 4'hF);
    rd(TEST_SETUP_OFS, 32'hFFFFFFFF, 32'hF);
    rd(8'h10, 32'hFFFFFFFF, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      wb(1'b1, TEST_SETUP_OFS, i == 2 ? 0 : 32'h1 | (i << 2), 4'hF);
      clr();
      hw(w, ^w, 1'b0);
      hw(w, ~^w, 1'b0);
      u_link_source_model.rest();
      // Falling-edge flag lands three edges after the last word clock edge
      tick(3);
      rd(ALARM_STATUS_OFS, 32'h1C00, i == 2 ? 0 : 32'h800 >> i);
    end
    wb(1'b1, TEST_SETUP_OFS, 32'h2, 4'hF);
    hw(16'h0, 1'b0, 1'b0);
    hw(16'h0, 1'b0, 1'b0);
    blk(blk_a, 1'b1);
    clr();
    blk(blk_b, ^blk_a);
    rd(ALARM_STATUS_OFS, 32'h1C00, 32'h0);
    blk(64'h0, ~^blk_b);
    rd(ALARM_STATUS_OFS, 32'h1C00, 32'h1000);
    wb(1'b1, TEST_SETUP_OFS, 32'h0, 4'hF);
    pll_locked_i <= 1'b0;
    pulse();
    wb(1'b1, ALARM_STATUS_OFS, 32'h0, 4'h1);
    rd(ALARM_STATUS_OFS, 32'h300, 32'h300);
    clr();
    rd(ALARM_STATUS_OFS, 32'h300, 32'h200);
    pll_locked_i <= 1'b1;
    tick(6);
    clr();
    rd(ALARM_STATUS_OFS, 32'h300, 32'h0);
    wb(1'b1, ALARM_MASK_OFS, 32'h100, 4'hF);
    rd(ALARM_MASK_OFS, 32'hFFFFFFFF, 32'h100);
    pulse();
    chk({31'h0, alarm_o}, 32'h1);
    wb(1'b1, ALARM_MASK_OFS, 32'h0, 4'hF);
    tick(3);
    chk({31'h0, alarm_o}, 32'h0);
    clr();
    wb(1'b1, ALARM_MASK_OFS, 32'h100, 4'hF);
    tick(3);
    chk({31'h0, alarm_o}, 32'h0);
    // Enable low freezes state, so a pulse then leaves no flag
    ce_i <= 1'b0;
    pulse();
    ce_i <= 1'b1;
    rd(ALARM_STATUS_OFS, 32'h100, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      wr_ptr_i <= wr_tab[i];
      tick(4);
      clr();
      rd(ALARM_STATUS_OFS, 32'h1F, {27'h0, fifo_exp[i]});
    end
    wr_ptr_i <= 8'h00;
    tick(4);
    clr();
    rd(ALARM_STATUS_OFS, 32'h1, 32'h1);
    wr_ptr_i <= 8'h01;
    conv_run <= 1'b0;
    tick(30);
    clr();
    rd(ALARM_STATUS_OFS, 32'h60, 32'h60);
    conv_run <= 1'b1;
    tick(10);
    clr();
    rd(ALARM_STATUS_OFS, 32'h40, 32'h0);
    wb(1'b1, TEST_SETUP_OFS, 32'h8, 4'hF);
    wb(1'b1, AUTO_SHUTOFF_OFS, 32'h4, 4'hF);
    clr();
    tick(5);
    chk({31'h0, analog_on_o}, 32'h1);
    wr_ptr_i <= rd_ptr_i;
    tick(4);
    wr_ptr_i <= 8'h01;
    tick(4);
    chk({31'h0, analog_on_o}, 32'h0);
    clr();
    tick(4);
    chk({31'h0, analog_on_o}, 32'h1);
    // Word clock is idle here, so its gone flag is always up
    wb(1'b1, AUTO_SHUTOFF_OFS, 32'h2, 4'hF);
    tick(4);
    chk({31'h0, analog_on_o}, 32'h0);
    wb(1'b1, AUTO_SHUTOFF_OFS, 32'h0, 4'hF);
    tx_enable_i <= 1'b0;
    tick(6);
    chk({31'h0, analog_on_o}, 32'h0);
    end_sim();
  end

  // Whole run needs about 44 us; wait about 45 times that before giving up
  initial
  begin
    #2000000;
    err_total++;
    end_sim();
  end
endmodule // input_parity_and_alarm_monitor_test
